// ---- core/cafo_map.vh ----
/*
 * Register map, field positions, reset values and clock-source codes of
 * the counter-array frequency output block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses, one word each.
 */
`ifndef CAFO_MAP_VH
`define CAFO_MAP_VH

`define CAFO_ADDR_W          6

// Word-aligned byte offsets
`define CAFO_OFS_CTRL        6'h00
`define CAFO_OFS_MODE        6'h04
`define CAFO_OFS_CNT_LOW     6'h08
`define CAFO_OFS_CNT_HIGH    6'h0C
`define CAFO_OFS_MOD_MODE    6'h10
`define CAFO_OFS_CMP_LOW     6'h14
`define CAFO_OFS_CMP_HIGH    6'h18
`define CAFO_OFS_STATUS      6'h1C

// Control register fields
`define CAFO_CTRL_RUN        0
`define CAFO_CTRL_FLAG       1

// Counter-array mode register fields
`define CAFO_MODE_CPS_LSB    1
`define CAFO_MODE_CPS_MSB    3

// Module mode register fields
`define CAFO_MM_CMP_EN       6
`define CAFO_MM_MATCH_EN     3
`define CAFO_MM_TOGGLE_EN    2
`define CAFO_MM_PWIDTH_EN    1

// Status register fields
`define CAFO_ST_PIN          0

// Reset values
`define CAFO_RST_BYTE        8'h00
`define CAFO_RST_CPS         3'h0

// Clock source select codes
`define CAFO_CPS_DIV12       3'h0
`define CAFO_CPS_DIV4        3'h1
`define CAFO_CPS_TIMER       3'h2
`define CAFO_CPS_EXT         3'h3
`define CAFO_CPS_DIV1        3'h4
`define CAFO_CPS_DIV8        3'h5

// Prescale terminal counts (divide by N -> count N-1)
`define CAFO_DIV12_LAST      4'hB
`define CAFO_DIV8_LAST       4'h7
`define CAFO_DIV4_LAST       4'h3

`endif

// ---- core/cafo_tick.v ----
/*
 * Counter-array clock enable generator: one-cycle tick per counter-array
 * clock, chosen by the clock source select code.
 * Assumes I_CLK domain; the external clock pin is asynchronous and is
 * synchronised here, the timer overflow pulse is on the same clock.
 */
`timescale 1ns/1ps
`include "cafo_map.vh"

module cafo_tick
(
    input  wire       i_clk,
    input  wire       i_nrst,
    input  wire [2:0] i_sel,
    input  wire       i_ext_pin,
    input  wire       i_timer_ovf,
    output reg        o_tick
);

    reg  [3:0] prescale;
    reg  [3:0] last;
    reg        ext_meta;
    reg        ext_sync;
    reg        ext_prev;
    reg        next_tick;

    always @*
    begin
        case (i_sel)
            `CAFO_CPS_DIV12: last = `CAFO_DIV12_LAST;
            `CAFO_CPS_DIV8:  last = `CAFO_DIV8_LAST;
            `CAFO_CPS_DIV4:  last = `CAFO_DIV4_LAST;
            default:         last = 4'h0;
        endcase
    end

    always @*
    begin
        case (i_sel)
            `CAFO_CPS_TIMER: next_tick = i_timer_ovf;
            `CAFO_CPS_EXT:   next_tick = ext_sync & ~ext_prev;
            `CAFO_CPS_DIV1:  next_tick = 1'b1;
            default:         next_tick = (prescale == last);
        endcase
    end

    // Two-stage sync; only the second stage feeds the edge detector
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            prescale <= 4'h0;
            o_tick   <= 1'b0;
        end
        else
        begin
            ext_meta <= i_ext_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            o_tick   <= next_tick;
            if (prescale >= last)
                prescale <= 4'h0;
            else
                prescale <= prescale + 4'h1;
        end
    end

endmodule

// ---- core/cafo_top.v ----
/*
 * Counter-array with one capture/compare module in frequency output mode,
 * reached over an Avalon-MM slave with waitrequest.
 * Registers sit at word-aligned byte offsets, fields in bits [7:0]:
 *   0x00 control: bit 0 run, bit 1 compare flag (write 0 clears it)
 *   0x04 counter-array mode: clock source select in bits [3:1]
 *   0x08 and 0x0C counter low and high bytes
 *   0x10 module mode: compare, match-flag, toggle, pulse-width enables
 *   0x14 and 0x18 compare low and high bytes
 *   0x1C status: bit 0 is the output pin level
 * Unmapped offsets read as zero; writes need byte enable 0.
 * A zero offset in the compare high byte means a half period of 256 counter clocks.
 * Assumes one clock, asynchronous active-low reset, a master that holds
 * its request until waitrequest is seen low.
 * Every access takes two clocks: waitrequest drops for one cycle and
 * read data, registered with it, holds until the next read.
 * The external clock pin may be asynchronous; the timer overflow is a
 * one-cycle pulse on I_CLK. Select codes 6 and 7 count every clock.
 */
// Decided for this implementation: the Avalon-MM slave port and the address map.
// Behaviour
// - In frequency mode, low compare byte equal to counter low byte toggles pin.
// - On each such match, high compare byte is added to low compare byte.
// - High byte is counter clocks between toggles; frequency is clock over 2x byte.
// - A high byte of zero acts as 256 counter clocks.
// - Frequency mode runs when compare, toggle and pulse-width enables are all set.
// - With compare and match-flag enables set, full 16-bit equality sets the compare flag.
// - Counter clock is the source picked by the clock source select field.
`timescale 1ns/1ps
`include "cafo_map.vh"

module cafo_top
(
    input  wire                    I_CLK,
    input  wire                    I_NRST,
    input  wire [`CAFO_ADDR_W-1:0] I_ADDRESS,
    input  wire                    I_READ,
    input  wire                    I_WRITE,
    input  wire [31:0]             I_WRITEDATA,
    input  wire [3:0]              I_BYTEENABLE,
    input  wire                    I_EXT_CLK_PIN,
    input  wire                    I_TIMER_OVF,
    output reg  [31:0]             O_READDATA,
    output reg                     O_WAITREQUEST,
    output reg                     O_MODULE_OUTPUT_PIN,
    output reg                     O_CAPTURE_COMPARE_FLAG
);

    // Software-visible state
    reg        counter_run;
    reg  [2:0] clock_source_select;
    reg  [7:0] counter_low;
    reg  [7:0] counter_high;
    reg        compare_enable;
    reg        match_flag_enable;
    reg        toggle_enable;
    reg        pulse_width_enable;
    reg  [7:0] compare_low_byte;
    reg  [7:0] compare_high_byte;

    // Next values
    reg  [7:0]  next_counter_low;
    reg  [7:0]  next_counter_high;
    reg  [7:0]  next_compare_low_byte;
    reg         next_pin;
    reg         next_flag;
    reg  [31:0] next_readdata;

    wire        tick;
    wire        wr_go;
    wire        rd_go;
    wire        wr_lane0;
    wire        freq_mode;
    wire        count_en;
    wire        low_match;
    wire        full_match;
    wire [15:0] counter_next16;
    wire        wr_ctrl;
    wire        wr_cnt_low;
    wire        wr_cnt_high;
    wire        wr_cmp_low;
    wire        toggle_go;
    wire        flag_set;
    wire        flag_clr;
    wire [7:0]  cmp_sum;

    // Bus strobes: a read is served on the edge where waitrequest drops, a write on the cycle after
    assign rd_go    = I_READ & O_WAITREQUEST;
    assign wr_go    = I_WRITE & ~O_WAITREQUEST;
    assign wr_lane0 = wr_go & I_BYTEENABLE[0];

    assign freq_mode  = compare_enable & toggle_enable & pulse_width_enable;
    assign count_en   = counter_run & tick;
    assign low_match  = (compare_low_byte == counter_low);
    assign full_match = ({compare_high_byte, compare_low_byte} ==
                         {counter_high, counter_low});
    assign counter_next16 = {counter_high, counter_low} + 16'h0001;

    // Per-register write strobes; byte lane 0 carries every field
    assign wr_ctrl     = wr_lane0 & (I_ADDRESS == `CAFO_OFS_CTRL);
    assign wr_cnt_low  = wr_lane0 & (I_ADDRESS == `CAFO_OFS_CNT_LOW);
    assign wr_cnt_high = wr_lane0 & (I_ADDRESS == `CAFO_OFS_CNT_HIGH);
    assign wr_cmp_low  = wr_lane0 & (I_ADDRESS == `CAFO_OFS_CMP_LOW);

    // Match events, each looked at once per counter-array clock
    assign toggle_go = count_en & freq_mode & low_match;
    assign cmp_sum   = compare_low_byte + compare_high_byte;
    assign flag_set  = count_en & compare_enable & match_flag_enable & full_match;
    assign flag_clr  = wr_ctrl & ~I_WRITEDATA[`CAFO_CTRL_FLAG];

    // Tick is registered: the counter moves one cycle after its source
    cafo_tick u_tick
    (
        .i_clk       (I_CLK),
        .i_nrst      (I_NRST),
        .i_sel       (clock_source_select),
        .i_ext_pin   (I_EXT_CLK_PIN),
        .i_timer_ovf (I_TIMER_OVF),
        .o_tick      (tick)
    );

    // Counter: software write wins over the running count
    always @*
    begin
        next_counter_low  = counter_low;
        next_counter_high = counter_high;
        if (count_en)
        begin
            next_counter_low  = counter_next16[7:0];
            next_counter_high = counter_next16[15:8];
        end
        if (wr_cnt_low)
            next_counter_low = I_WRITEDATA[7:0];
        if (wr_cnt_high)
            next_counter_high = I_WRITEDATA[7:0];
    end

    // Toggle and advance once per counter-array clock, so each counter
    // value is examined exactly once. A zero offset adds nothing, so the
    // next match waits a full counter lap of 256 clocks.
    always @*
    begin
        next_compare_low_byte = compare_low_byte;
        next_pin              = O_MODULE_OUTPUT_PIN;
        if (toggle_go)
        begin
            next_pin              = ~O_MODULE_OUTPUT_PIN;
            next_compare_low_byte = cmp_sum;
        end
        // Software write wins over the advance; the high byte is
        // never written by hardware, so the interval stays put
        if (wr_cmp_low)
            next_compare_low_byte = I_WRITEDATA[7:0];
    end

    // Flag: hardware set wins over a software clear in the same cycle
    always @*
    begin
        next_flag = O_CAPTURE_COMPARE_FLAG;
        if (flag_clr)
            next_flag = 1'b0;
        // Match flag enable is normally left clear here
        if (flag_set)
            next_flag = 1'b1;
    end

    // Read mux; unmapped addresses read as zero
    always @*
    begin
        next_readdata = 32'h0000_0000;
        case (I_ADDRESS)
            `CAFO_OFS_CTRL:
            begin
                next_readdata[`CAFO_CTRL_RUN]  = counter_run;
                next_readdata[`CAFO_CTRL_FLAG] = O_CAPTURE_COMPARE_FLAG;
            end
            `CAFO_OFS_MODE:
            begin
                next_readdata[`CAFO_MODE_CPS_MSB:`CAFO_MODE_CPS_LSB] = clock_source_select;
            end
            `CAFO_OFS_CNT_LOW:
            begin
                next_readdata[7:0] = counter_low;
            end
            `CAFO_OFS_CNT_HIGH:
            begin
                next_readdata[7:0] = counter_high;
            end
            `CAFO_OFS_MOD_MODE:
            begin
                next_readdata[`CAFO_MM_CMP_EN]    = compare_enable;
                next_readdata[`CAFO_MM_MATCH_EN]  = match_flag_enable;
                next_readdata[`CAFO_MM_TOGGLE_EN] = toggle_enable;
                next_readdata[`CAFO_MM_PWIDTH_EN] = pulse_width_enable;
            end
            `CAFO_OFS_CMP_LOW:
            begin
                next_readdata[7:0] = compare_low_byte;
            end
            `CAFO_OFS_CMP_HIGH:
            begin
                next_readdata[7:0] = compare_high_byte;
            end
            `CAFO_OFS_STATUS:
            begin
                next_readdata[`CAFO_ST_PIN] = O_MODULE_OUTPUT_PIN;
            end
            default:
            begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    // Waitrequest: high by default, low for one cycle per request
    // Registered answer costs a cycle but keeps both bus outputs on flops
    always @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_WAITREQUEST <= 1'b1;
            O_READDATA    <= 32'h0000_0000;
        end
        else
        begin
            if ((I_READ || I_WRITE) && O_WAITREQUEST)
                O_WAITREQUEST <= 1'b0;
            else
                O_WAITREQUEST <= 1'b1;
            if (rd_go)
                O_READDATA <= next_readdata;
        end
    end

    // Configuration registers
    always @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            counter_run         <= 1'b0;
            clock_source_select <= `CAFO_RST_CPS;
            compare_enable      <= 1'b0;
            match_flag_enable   <= 1'b0;
            toggle_enable       <= 1'b0;
            pulse_width_enable  <= 1'b0;
            compare_high_byte   <= `CAFO_RST_BYTE;
        end
        else if (wr_lane0)
        begin
            case (I_ADDRESS)
                `CAFO_OFS_CTRL:
                begin
                    counter_run <= I_WRITEDATA[`CAFO_CTRL_RUN];
                end
                `CAFO_OFS_MODE:
                begin
                    clock_source_select <=
                        I_WRITEDATA[`CAFO_MODE_CPS_MSB:`CAFO_MODE_CPS_LSB];
                end
                `CAFO_OFS_MOD_MODE:
                begin
                    compare_enable     <= I_WRITEDATA[`CAFO_MM_CMP_EN];
                    match_flag_enable  <= I_WRITEDATA[`CAFO_MM_MATCH_EN];
                    toggle_enable      <= I_WRITEDATA[`CAFO_MM_TOGGLE_EN];
                    pulse_width_enable <= I_WRITEDATA[`CAFO_MM_PWIDTH_EN];
                end
                `CAFO_OFS_CMP_HIGH:
                begin
                    compare_high_byte <= I_WRITEDATA[7:0];
                end
                default:
                begin
                    counter_run <= counter_run;
                end
            endcase
        end
    end

    // Counter, compare low byte, pin and flag
    always @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            counter_low            <= `CAFO_RST_BYTE;
            counter_high           <= `CAFO_RST_BYTE;
            compare_low_byte       <= `CAFO_RST_BYTE;
            O_MODULE_OUTPUT_PIN    <= 1'b0;
            O_CAPTURE_COMPARE_FLAG <= 1'b0;
        end
        else
        begin
            counter_low            <= next_counter_low;
            counter_high           <= next_counter_high;
            compare_low_byte       <= next_compare_low_byte;
            O_MODULE_OUTPUT_PIN    <= next_pin;
            O_CAPTURE_COMPARE_FLAG <= next_flag;
        end
    end

endmodule

// ---- test/cafo_pin_model.sv ----
/*
 Load on the square-wave pin: counts toggles and the clocks between them.
 Assumes the pin is a registered level on the same clock.
*/
`timescale 1ns/1ps
module cafo_pin_model
(
    input  wire    i_clk,
    input  wire    i_nrst,
    input  wire    i_pin,
    output integer o_toggles,
    output integer o_gap
);
    integer cyc;
    integer last;
    reg     prev;
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cyc <= 0;
            last <= 0;
            prev <= 1'b0;
            o_toggles <= 0;
            o_gap <= 0;
        end
        else
        begin
            cyc <= cyc + 1;
            prev <= i_pin;
            if (i_pin !== prev)
            begin
                o_toggles <= o_toggles + 1;
                o_gap <= cyc - last;
                last <= cyc;
            end
        end
    end
endmodule

// ---- test/cafo_sva.sv ----
/*
 Checker for the cafo_top bus handshake, read data and compare flag.
 Assumes binding to cafo_top with one clock and async active-low reset.
*/
`timescale 1ns/1ps
module cafo_sva
(
    input wire        I_CLK,
    input wire        I_NRST,
    input wire [5:0]  I_ADDRESS,
    input wire        I_READ,
    input wire        I_WRITE,
    input wire [31:0] I_WRITEDATA,
    input wire [3:0]  I_BYTEENABLE,
    input wire [31:0] O_READDATA,
    input wire        O_WAITREQUEST,
    input wire        O_CAPTURE_COMPARE_FLAG
);
    wire req = I_READ | I_WRITE;
    wire ack = ~O_WAITREQUEST;
    wire ctl = I_WRITE & ack & (I_ADDRESS == 6'h00) & I_BYTEENABLE[0];
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    a_wait_answer: assert property (req && O_WAITREQUEST |=> !O_WAITREQUEST)
        else $error("request not answered next cycle");
    a_wait_single: assert property (!O_WAITREQUEST |=> O_WAITREQUEST)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!req |=> O_WAITREQUEST)
        else $error("answer without request");
    a_rdata_hold: assert property ($changed(O_READDATA) |-> $past(I_READ && O_WAITREQUEST))
        else $error("read data moved without read");
    a_write_rdata: assert property (I_WRITE && ack |=> $stable(O_READDATA))
        else $error("write disturbed read data");
    a_unmapped_zero: assert property (I_READ && ack && (I_ADDRESS[1:0] != 2'h0
        || I_ADDRESS > 6'h1C) |-> O_READDATA == 32'h0)
        else $error("unmapped read not zero");
    a_flag_clear: assert property ($fell(O_CAPTURE_COMPARE_FLAG) |-> $past(ctl && !I_WRITEDATA[1]))
        else $error("flag dropped without clearing write");
    a_flag_keep: assert property (ctl && I_WRITEDATA[1] && O_CAPTURE_COMPARE_FLAG |=> O_CAPTURE_COMPARE_FLAG)
        else $error("flag lost on keeping write");
endmodule
bind cafo_top cafo_sva i_sva (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_ADDRESS(I_ADDRESS),
    .I_READ(I_READ), .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA),
    .I_BYTEENABLE(I_BYTEENABLE), .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST),
    .O_CAPTURE_COMPARE_FLAG(O_CAPTURE_COMPARE_FLAG));

// ---- test/cafo_top_tb_top.sv ----
/*
 Self-checking bench for cafo_top: Avalon master, timer and pin clock sources.
 Assumes cafo_map.vh on the include path and the pin model beside the design.
*/
`timescale 1ns/1ps
`include "cafo_map.vh"
module cafo_top_tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic        ext = 1'b0;
    logic        ovf = 1'b0;
    wire  [31:0] rdata;
    wire         wait_req;
    wire         pin;
    wire         flag;
    integer      toggles;
    integer      gap;
    integer      err_count = 0;
    integer      n_tests = 0;
    integer      seed = 32'h33fb;
    integer      src_cnt = 0;
    integer      i;
    integer      base;
    logic [31:0] q;
    logic [7:0]  h;
    logic [2:0]  sels [0:5] = '{3'h4, 3'h1, 3'h5, 3'h0, 3'h2, 3'h3};
    integer      divs [0:5] = '{1, 4, 8, 12, 3, 6};
    always #12.5 clk = ~clk;
    // Slow sources: timer pulse every 3 clocks, pin clock period 6
    always @(posedge clk)
    begin
        src_cnt <= (src_cnt + 1) % 3;
        ovf <= (src_cnt == 0);
        if (src_cnt == 0)
            ext <= ~ext;
    end
    cafo_top i_dut (.I_CLK(clk), .I_NRST(nrst), .I_ADDRESS(address), .I_READ(read),
        .I_WRITE(write), .I_WRITEDATA(wdata), .I_BYTEENABLE(be), .I_EXT_CLK_PIN(ext),
        .I_TIMER_OVF(ovf), .O_READDATA(rdata), .O_WAITREQUEST(wait_req),
        .O_MODULE_OUTPUT_PIN(pin), .O_CAPTURE_COMPARE_FLAG(flag));
    cafo_pin_model i_load (.i_clk(clk), .i_nrst(nrst), .i_pin(pin), .o_toggles(toggles),
        .o_gap(gap));
    task test_done;
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
        input logic [3:0] e, output logic [31:0] r);
        integer k;
        k = 0;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        wdata <= {24'h0, d};
        be <= e;
        do
        begin
            @(posedge clk);
            k = k + 1;
        end while (wait_req !== 1'b0 && k < 20);
        r = rdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 20)
        begin
            check("bus timeout", 32'h1, 32'h0);
            test_done;
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF, q);
    endtask
    task cfg(input logic [2:0] sel, input logic [7:0] hi, input logic [7:0] mm);
        wr(`CAFO_OFS_CTRL, 8'h00);
        wr(`CAFO_OFS_CNT_LOW, 8'h00);
        wr(`CAFO_OFS_CNT_HIGH, 8'h00);
        wr(`CAFO_OFS_CMP_LOW, 8'h00);
        wr(`CAFO_OFS_CMP_HIGH, hi);
        wr(`CAFO_OFS_MOD_MODE, mm);
        wr(`CAFO_OFS_MODE, {4'h0, sel, 1'b0});
        wr(`CAFO_OFS_CTRL, 8'h01);
    endtask
    // Waits for n more toggles or, failing, for a flag rise when n is 0
    task wait_ev(input integer n, input integer lim);
        integer k;
        k = 0;
        base = toggles;
        while ((n > 0 ? toggles < base + n : flag !== 1'b1) && k < lim)
        begin
            @(posedge clk);
            k = k + 1;
        end
        if (k >= lim)
        begin
            check("event timeout", 32'h1, 32'h0);
            test_done;
        end
    endtask
    function integer exp_gap(input integer div, input logic [7:0] hi);
        exp_gap = div * (hi == 8'h00 ? 256 : hi);
    endfunction
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
        begin
            bus(1'b0, i * 4, 8'h00, 4'hF, q);
            check("reset value", q, 32'h0);
        end
        bus(1'b0, 6'h21, 8'h00, 4'hF, q);
        check("unmapped read", q, 32'h0);
        bus(1'b1, `CAFO_OFS_CMP_HIGH, 8'h5A, 4'hE, q);
        bus(1'b0, `CAFO_OFS_CMP_HIGH, 8'h00, 4'hF, q);
        check("masked write", q, 32'h0);
        for (i = 0; i < 8; i = i + 1)
        begin
            h = (i == 6) ? 8'h00 : (i == 7) ? 8'h01 : 8'h01 + ($unsigned($random(seed)) % 255);
            // Match flag enable left clear, as software should
            cfg(i < 6 ? sels[i] : 3'h4, h, 8'h46);
            wait_ev(3, 3 * exp_gap(12, h) + 200);
            check("half period", gap, exp_gap(i < 6 ? divs[i] : 1, h));
            bus(1'b0, `CAFO_OFS_CMP_HIGH, 8'h00, 4'hF, q);
            check("high byte kept", q, {24'h0, h});
            check("flag idle", flag, 1'b0);
        end
        wr(`CAFO_OFS_CTRL, 8'h00);
        bus(1'b0, `CAFO_OFS_STATUS, 8'h00, 4'hF, q);
        check("pin status", q[0], toggles[0]);
        for (i = 0; i < 3; i = i + 1)
        begin
            cfg(3'h4, 8'h02, 8'h46 & ~(8'h40 >> (i == 0 ? 0 : i + 3)));
            base = toggles;
            repeat (50) @(posedge clk);
            check("not freq mode", toggles, base);
        end
        cfg(3'h4, 8'h03, 8'h4E);
        // Full match first comes at count 16'h0300, about 770 clocks on
        repeat (700) @(posedge clk);
        check("flag early", flag, 1'b0);
        wait_ev(0, 200);
        check("flag set", flag, 1'b1);
        // Stop first: matches recur every 3 clocks and a set beats a clear
        wr(`CAFO_OFS_CTRL, 8'h02);
        @(posedge clk);
        check("flag kept", flag, 1'b1);
        wr(`CAFO_OFS_CTRL, 8'h00);
        @(posedge clk);
        check("flag cleared", flag, 1'b0);
        test_done;
    end
endmodule
